// ### design/tcm_compare_unit.sv
// 8-bit timer with one compare output channel and wishbone registers
// Notes on behaviour
// - compare counter with compare value continuously
// - match flag sets one timer tick later
// - flag plus enable requests irq, ack clears
// - writing one clears match flag
// - pwm modes buffer compare, others bypass
// - cpu reaches buffer or active register
// - force strobe acts like match outside pwm modes, no flag
// - counter write blocks next tick match
// - output state kept across mode changes
// - action select takes effect immediately
// - nonzero action overrides port data value
// - action zero leaves output unchanged
// - action set/clear/toggle or pwm polarity
// - normal mode counts up and wraps
// - normal overflow flag as counter becomes zero
// - overflow flag cleared by irq service
// - clear mode restarts after equal value
// - low new compare value runs to wrap
// - toggle each match in clear mode
// - toggle frequency set by compare value
// - clear mode overflow at max to zero
// - mode three is single slope pwm
// - mode one is dual slope pwm
// - counter write beats count and clear
`timescale 1ns/1ps
`default_nettype none
module tcm_compare_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // timer clock enable from prescaler
  input wire logic timerTick,
  // interrupt request and service
  output logic irqCompare,
  output logic irqOverflow,
  input wire logic irqCompareAck,
  input wire logic irqOverflowAck,
  // port pin
  input wire logic portData,
  input wire logic portDir,
  output logic pinOut,
  output logic pinOeN
);
  import tcm_pkg::*;

  // output action applied at a match or force
  function automatic logic actOn(input logic cur, input logic [1:0] act,
                                 input logic pwm, input logic clrPhase);
    logic res;
    res = cur;
    case (act)
      ACT_TOGGLE: res = ~cur;
      ACT_CLEAR: res = pwm ? ~clrPhase : 1'b0;
      ACT_SET: res = pwm ? clrPhase : 1'b1;
      default: res = cur;
    endcase
    return res;
  endfunction

  logic [1:0] waveMode;
  logic [1:0] actionSel;
  logic [7:0] count;
  logic [7:0] compareActive;
  logic [7:0] compareBuffer;
  logic countDown;
  logic blockMatch;
  logic matchSeen;
  logic compareFlag;
  logic overflowFlag;
  logic compareIrqEn;
  logic overflowIrqEn;
  logic outState;

  // bus decode; writes act on the acking edge
  wire busReq = wbCyc & wbStb;
  wire wrEn = busReq & wbWe & wbAck & wbSel[0];
  wire wrCtrl = wrEn & (wbAdr == OFS_CTRL);
  wire wrForce = wrEn & (wbAdr == OFS_FORCE) & wbDatIn[FORCE_BIT];
  wire wrCount = wrEn & (wbAdr == OFS_COUNT);
  wire wrCompare = wrEn & (wbAdr == OFS_COMPARE);
  wire wrFlags = wrEn & (wbAdr == OFS_FLAGS);
  wire wrIrqEn = wrEn & (wbAdr == OFS_IRQEN);

  // mode decode
  wire isPwm = waveMode[0];
  wire isPc = (waveMode == WGM_PCPWM);
  wire isFast = (waveMode == WGM_FASTPWM);
  wire isClear = (waveMode == WGM_CLEAR);

  // comparator, gated for a tick after a counter write
  wire equal = (count == compareActive);
  wire match = equal & ~blockMatch;
  wire matchEvt = timerTick & match;
  wire atMax = (count == CNT_MAX);
  wire atBottom = (count == CNT_BOTTOM);

  // next count; the counter write itself wins elsewhere
  wire [7:0] countUp = count + 8'h01;
  wire [7:0] countDn = count - 8'h01;
  wire pcTurnDown = isPc & ~countDown & atMax;
  wire pcTurnUp = isPc & countDown & atBottom;
  wire pcDownNow = (countDown & ~pcTurnUp) | pcTurnDown;
  wire [7:0] next_count =
    (isClear & equal) ? CNT_BOTTOM :
    (isPc & pcDownNow) ? countDn : countUp;

  // overflow as the counter becomes zero
  wire ovfEvt = timerTick & ~wrCount &
    (isPc ? (pcDownNow & (count == 8'h01))
          : (atMax & ~(isClear & equal)));
  wire clearMatchTop = isClear & equal & atMax;
  wire ovfSet = ovfEvt | (timerTick & ~wrCount & clearMatchTop);

  // double buffer loads at top (dual slope) or wrap (single slope)
  wire bufLoad = isPwm & timerTick & atMax;
  wire fastBottom = isFast & timerTick & atMax & actionSel[1];

  // output state next value
  wire matchOut = actOn(outState, actionSel, isPwm,
                        isFast | ~countDown);
  wire forceOut = actOn(outState, actionSel, 1'b0, 1'b0);
  wire next_outState =
    fastBottom ? (actionSel == ACT_CLEAR) :
    matchEvt ? matchOut :
    (wrForce & ~isPwm) ? forceOut : outState;

  // control registers; action select unbuffered
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      waveMode <= WGM_NORMAL;
      actionSel <= ACT_NONE;
      compareIrqEn <= 1'b0;
      overflowIrqEn <= 1'b0;
    end else begin
      if (wrCtrl) begin
        waveMode <= wbDatIn[MODE_LSB +: 2];
        actionSel <= wbDatIn[ACTION_LSB +: 2];
      end
      if (wrIrqEn) begin
        compareIrqEn <= wbDatIn[CMPF_BIT];
        overflowIrqEn <= wbDatIn[OVFF_BIT];
      end
    end
  end

  // counter, direction and match blocking
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count <= RST_COUNT;
      countDown <= 1'b0;
      blockMatch <= 1'b0;
    end else begin
      if (wrCount) begin
        count <= wbDatIn[7:0];
      end else if (timerTick) begin
        count <= next_count;
      end
      if (timerTick) begin
        countDown <= isPc & pcDownNow; // stale direction would leak into pc
      end
      if (wrCount) begin
        blockMatch <= 1'b1;
      end else if (timerTick) begin
        blockMatch <= 1'b0;
      end
    end
  end

  // compare value: buffered in pwm, direct otherwise
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      compareActive <= RST_COMPARE;
      compareBuffer <= RST_COMPARE;
    end else begin
      if (wrCompare) begin
        compareBuffer <= wbDatIn[7:0];
      end
      if (wrCompare & ~isPwm) begin
        compareActive <= wbDatIn[7:0];
      end else if (bufLoad) begin
        compareActive <= compareBuffer;
      end
    end
  end

  // flags; a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      matchSeen <= 1'b0;
      compareFlag <= 1'b0;
      overflowFlag <= 1'b0;
    end else begin
      if (timerTick) begin
        matchSeen <= match;
      end
      if (timerTick & matchSeen) begin
        compareFlag <= 1'b1;
      end else if (irqCompareAck |
                   (wrFlags & wbDatIn[CMPF_BIT])) begin
        compareFlag <= 1'b0;
      end
      if (ovfSet) begin
        overflowFlag <= 1'b1;
      end else if (irqOverflowAck |
                   (wrFlags & wbDatIn[OVFF_BIT])) begin
        overflowFlag <= 1'b0;
      end
    end
  end

  // output state survives mode changes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outState <= 1'b0;
    end else begin
      outState <= next_outState;
    end
  end

  // read mux; unmapped offsets read zero
  wire [7:0] compareRead = isPwm ? compareBuffer : compareActive;
  wire [31:0] rdMux =
    (wbAdr == OFS_CTRL) ? {28'h0000_000, actionSel, waveMode} :
    (wbAdr == OFS_COUNT) ? {24'h0000_00, count} :
    (wbAdr == OFS_COMPARE) ? {24'h0000_00, compareRead} :
    (wbAdr == OFS_FLAGS) ? {30'h0000_0000, overflowFlag, compareFlag} :
    (wbAdr == OFS_IRQEN) ? {30'h0000_0000, overflowIrqEn, compareIrqEn} :
    32'h0000_0000;

  // single wait state answer; ack drops after one cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else begin
      wbAck <= busReq & ~wbAck;
      if (busReq & ~wbAck & ~wbWe) begin
        wbDatOut <= rdMux;
      end
    end
  end

  // interrupt lines and pin override
  assign irqCompare = compareFlag & compareIrqEn;
  assign irqOverflow = overflowFlag & overflowIrqEn;
  assign pinOut = (actionSel != ACT_NONE) ? outState : portData;
  assign pinOeN = ~portDir;

  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  // tick-sampled match, kept apart from the flag path it checks
  logic chkMatchTick;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      chkMatchTick <= 1'b0;
    end else if (timerTick) begin
      chkMatchTick <= equal & ~blockMatch;
    end
  end

  a_flag_one_late: assert property (
    timerTick & chkMatchTick |=> compareFlag)
    else $error("match flag not set one tick after match");
  a_flag_not_early: assert property (
    !compareFlag & !(timerTick & matchSeen) |=> !compareFlag)
    else $error("match flag set without delayed match");
  a_irq_request: assert property (
    compareFlag & compareIrqEn |-> irqCompare)
    else $error("compare irq missing");
  a_w1c_flag: assert property (
    wrFlags & wbDatIn[CMPF_BIT] & compareFlag &
      !(timerTick & matchSeen) |=> !compareFlag)
    else $error("write one did not clear match flag");
  a_write_zero: assert property (
    wrFlags & !wbDatIn[CMPF_BIT] & compareFlag & !irqCompareAck
      |=> compareFlag)
    else $error("write zero changed match flag");
  a_buffer_hold: assert property (
    isPwm & !bufLoad & !$past(wrCtrl) |=> $stable(compareActive))
    else $error("active compare changed outside update point");
  a_direct_write: assert property (
    wrCompare & !isPwm |=> compareActive == $past(wbDatIn[7:0]))
    else $error("direct compare write lost");
  a_force_noflag: assert property (
    wrForce & !isPwm & !timerTick & !matchSeen |=> !$rose(compareFlag))
    else $error("force set match flag");
  a_block_match: assert property (
    wrCount |=> !match until_with timerTick)
    else $error("match not blocked after counter write");
  a_count_write: assert property (
    wrCount |=> count == $past(wbDatIn[7:0]))
    else $error("counter write lost to counting");
  a_action_none: assert property (
    actionSel == ACT_NONE & !fastBottom & !wrCtrl |=> $stable(outState))
    else $error("output moved with no action");
  a_clear_restart: assert property (
    timerTick & isClear & equal & !wrCount |=> count == CNT_BOTTOM)
    else $error("clear mode did not restart");
  a_normal_wrap: assert property (
    timerTick & waveMode == WGM_NORMAL & atMax & !wrCount
      |=> count == CNT_BOTTOM ##0 overflowFlag)
    else $error("normal wrap or overflow wrong");
  a_pin_override: assert property (
    actionSel != ACT_NONE |-> pinOut == outState && pinOeN == !portDir)
    else $error("pin override wrong");
  a_bus_ack: assert property (
    busReq & !wbAck |=> wbAck ##1 !wbAck)
    else $error("bus ack timing wrong");
  a_ovf_service: assert property (
    irqOverflowAck & !ovfSet |=> !overflowFlag)
    else $error("overflow flag kept after service");
  a_ovf_hold: assert property (
    overflowFlag & !irqOverflowAck & !(wrFlags & wbDatIn[OVFF_BIT])
      |=> overflowFlag)
    else $error("overflow flag cleared by hardware");
  a_irq_ovf: assert property (
    overflowFlag & overflowIrqEn |-> irqOverflow)
    else $error("overflow irq missing");
  a_clear_ovf: assert property (
    timerTick & isClear & atMax & !wrCount |=> overflowFlag)
    else $error("clear mode overflow missing");
  a_toggle_match: assert property (
    matchEvt & isClear & actionSel == ACT_TOGGLE
      |=> outState != $past(outState))
    else $error("clear mode toggle missing");
  a_force_action: assert property (
    wrForce & !isPwm & !matchEvt & actionSel[1]
      |=> outState == $past(actionSel[0]))
    else $error("forced action wrong");
  a_mode_keeps: assert property (
    wrCtrl & !matchEvt & !fastBottom |=> $stable(outState))
    else $error("output state moved on mode change");
  a_fast_bottom: assert property (
    isFast & timerTick & atMax & actionSel == ACT_CLEAR |=> outState)
    else $error("fast pwm output not set at bottom");
  a_fast_wrap: assert property (
    timerTick & isFast & atMax & !wrCount
      |=> count == CNT_BOTTOM ##0 overflowFlag)
    else $error("fast pwm wrap or overflow wrong");
  a_pc_turn: assert property (
    timerTick & isPc & atMax & !wrCount |=> count == CNT_MAX - 8'h01)
    else $error("dual slope did not turn at max");
  a_pc_bottom_ovf: assert property (
    timerTick & isPc & countDown & count == 8'h01 & !wrCount
      |=> overflowFlag)
    else $error("dual slope overflow missing at bottom");
  a_buffer_load: assert property (
    bufLoad |=> compareActive == $past(compareBuffer))
    else $error("buffered compare not loaded at top");
  a_pin_follow: assert property (
    actionSel == ACT_NONE |-> pinOut == portData)
    else $error("pin left port data with no action");

  c_toggle: cover property (matchEvt & isClear & actionSel == ACT_TOGGLE);
  c_force: cover property (wrForce & !isPwm ##1 $changed(outState));
  c_buffer: cover property (bufLoad & compareBuffer != compareActive);
  c_set_wins: cover property (timerTick & matchSeen & irqCompareAck);
  c_fast_bottom: cover property (fastBottom & outState == 1'b0);
endmodule
`default_nettype wire

// ### design/tcm_pkg.sv
// constants for the timer compare output channel
package tcm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FORCE = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_COMPARE = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_IRQEN = 8'h14;
  // field positions
  localparam int MODE_LSB = 0;
  localparam int ACTION_LSB = 2;
  localparam int FORCE_BIT = 0;
  localparam int CMPF_BIT = 0;
  localparam int OVFF_BIT = 1;
  // reset values and counter limits
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  // waveform modes
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PCPWM = 2'h1;
  localparam logic [1:0] WGM_CLEAR = 2'h2;
  localparam logic [1:0] WGM_FASTPWM = 2'h3;
  // output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
endpackage

// ### bench/tcm_port_model.sv
// general port pin logic beside the compare output channel
`timescale 1ns/1ps
`default_nettype none
module tcm_port_model (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // requests from the bench
  input wire logic dataReq,
  input wire logic dirReq,
  // port register outputs
  output logic portData,
  output logic portDir,
  // pin driven by the channel
  input wire logic pinOut,
  input wire logic pinOeN,
  output logic pinLevel
);
  // port registers load on the clock like real port bits
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      portData <= 1'b0;
      portDir <= 1'b0;
    end else begin
      portData <= dataReq;
      portDir <= dirReq;
    end
  end
  // released pin falls to its pull-down, not to the last value
  assign pinLevel = pinOeN ? 1'b0 : pinOut;
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the timer compare output channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tcm_pkg::*;
  logic mclk, nrst, wbCyc, wbStb, wbWe, wbAck, timerTick, cmpAck, ovfAck;
  logic dataReq, dirReq, portData, portDir, pinOut, pinOeN, pinLevel;
  logic irqCompare, irqOverflow, st;
  logic [7:0] wbAdr, q, cv;
  logic [3:0] wbSel;
  logic [31:0] wbDatIn, wbDatOut;
  int failures, n_compared, seed;
  tcm_compare_unit dut (.mclk(mclk), .nrst(nrst), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .timerTick(timerTick), .irqCompare(irqCompare),
    .irqOverflow(irqOverflow), .irqCompareAck(cmpAck),
    .irqOverflowAck(ovfAck), .portData(portData), .portDir(portDir),
    .pinOut(pinOut), .pinOeN(pinOeN));
  tcm_port_model port (.mclk(mclk), .nrst(nrst), .dataReq(dataReq),
    .dirReq(dirReq), .portData(portData), .portDir(portDir),
    .pinOut(pinOut), .pinOeN(pinOeN), .pinLevel(pinLevel));
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // expected count n ticks after zero in clear-on-match mode
  function automatic logic [7:0] ctcCount(input logic [7:0] c, input int n);
    return 8'(n % (int'(c) + 1));
  endfunction
  // expected output state after a match with a given action
  function automatic logic actNext(input logic [1:0] a, input logic s);
    return (a == ACT_SET) ? 1'b1 : (a == ACT_CLEAR) ? 1'b0 :
           (a == ACT_TOGGLE) ? ~s : s;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'h1;
    wbDatIn <= {24'h00_0000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    q = wbDatOut[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  // timer ticks spaced one idle cycle apart
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      timerTick <= 1'b1;
      @(posedge mclk);
      timerTick <= 1'b0;
    end
  endtask
  task automatic settle;
    @(posedge mclk);
    @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(4 * 30000);
    failures++;
    give_verdict();
  end
  initial begin
    seed = 94;
    {wbCyc, wbStb, wbWe, timerTick, cmpAck, ovfAck, dataReq, st} = '0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatIn = 32'h0000_0000;
    dirReq = 1'b1;
    nrst = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    wb(0, OFS_COUNT, 8'h00);
    chk(q, RST_COUNT);
    wb(0, 8'h1C, 8'h00);
    chk(q, 8'h00);
    // normal mode wrap sets overflow exactly as count hits zero
    wb(1, OFS_COUNT, 8'hFD);
    ticks(2);
    wb(0, OFS_FLAGS, 8'h00);
    chk(q, 8'h00);
    ticks(1);
    wb(0, OFS_COUNT, 8'h00);
    chk(q, CNT_BOTTOM);
    wb(0, OFS_FLAGS, 8'h00);
    chk(q, 8'h02);
    wb(1, OFS_FLAGS, 8'h00);
    wb(0, OFS_FLAGS, 8'h00);
    chk(q, 8'h02);
    wb(1, OFS_FLAGS, 8'h02);
    wb(0, OFS_FLAGS, 8'h00);
    chk(q, 8'h00);
    $display("normal mode test done");
    // forced match for every nonzero action, flags untouched
    for (int a = 3; a > 0; a--) begin
      wb(1, OFS_CTRL, {4'h0, 2'(a), WGM_NORMAL});
      wb(1, OFS_FORCE, 8'h01);
      st = actNext(2'(a), st);
      settle();
      chk(pinLevel, st);
      wb(0, OFS_FLAGS, 8'h00);
      chk(q, 8'h00);
    end
    $display("force test done");
    // counter write equal to compare blocks the next match
    wb(1, OFS_CTRL, 8'h00);
    wb(1, OFS_COMPARE, 8'h40);
    wb(1, OFS_COUNT, 8'h40);
    ticks(3);
    wb(0, OFS_FLAGS, 8'h00);
    chk(q, 8'h00);
    @(posedge mclk);
    dataReq <= 1'($random(seed));
    settle();
    chk(pinLevel, dataReq);
    @(posedge mclk);
    dirReq <= 1'b0;
    settle();
    chk(pinOeN, 1'b1);
    @(posedge mclk);
    dirReq <= 1'b1;
    $display("blocking test done");
    // compare interrupt raised then cleared by service
    wb(1, OFS_IRQEN, 8'h01);
    wb(1, OFS_COMPARE, 8'h44);
    ticks(5);
    settle();
    chk(irqCompare, 1'b1);
    @(posedge mclk);
    cmpAck <= 1'b1;
    @(posedge mclk);
    cmpAck <= 1'b0;
    settle();
    chk(irqCompare, 1'b0);
    $display("interrupt test done");
    // clear-on-match toggling with random tops
    repeat (3) begin
      cv = (8'($random(seed)) & 8'h0F) | 8'h01;
      wb(1, OFS_CTRL, {4'h0, ACT_TOGGLE, WGM_CLEAR});
      settle();
      chk(pinLevel, st);
      wb(1, OFS_COMPARE, cv);
      wb(1, OFS_COUNT, 8'h00);
      wb(1, OFS_FLAGS, 8'h03);
      ticks(int'(cv));
      wb(0, OFS_FLAGS, 8'h00);
      chk(q, 8'h00);
      ticks(2);
      wb(0, OFS_COUNT, 8'h00);
      chk(q, ctcCount(cv, int'(cv) + 2));
      wb(0, OFS_FLAGS, 8'h00);
      chk(q, 8'h01);
      st = ~st;
      settle();
      chk(pinLevel, st);
    end
    $display("clear mode test done");
    // fast pwm: set at bottom, overflow service, buffered compare
    wb(1, OFS_IRQEN, 8'h02);
    wb(1, OFS_CTRL, {4'h0, ACT_CLEAR, WGM_FASTPWM});
    wb(1, OFS_COUNT, 8'hFE);
    ticks(2);
    settle();
    chk(pinLevel, 1'b1);
    chk(irqOverflow, 1'b1);
    @(posedge mclk);
    ovfAck <= 1'b1;
    @(posedge mclk);
    ovfAck <= 1'b0;
    settle();
    chk(irqOverflow, 1'b0);
    wb(1, OFS_COMPARE, 8'h80);
    wb(0, OFS_COMPARE, 8'h00);
    chk(q, 8'h80);
    // new value stays in the buffer until the wrap
    wb(1, OFS_COUNT, 8'h7F);
    ticks(2);
    settle();
    chk(pinLevel, 1'b1);
    wb(1, OFS_COUNT, 8'hFE);
    ticks(2);
    wb(1, OFS_COUNT, 8'h7F);
    ticks(2);
    settle();
    chk(pinLevel, 1'b0);
    // dual slope turns down at max
    wb(1, OFS_CTRL, {4'h0, ACT_NONE, WGM_PCPWM});
    wb(1, OFS_COUNT, 8'hFE);
    ticks(3);
    wb(0, OFS_COUNT, 8'h00);
    chk(q, 8'hFD);
    $display("pwm test done");
    give_verdict();
  end
endmodule
`default_nettype wire
